// ==== ecp_fifo_map.svh ====
`ifndef ECP_FIFO_MAP_SVH
`define ECP_FIFO_MAP_SVH

// register byte addresses
`define OFF_ADDR_RLE     12'h000
`define OFF_DATA         12'h400
`define OFF_CTRL         12'h404
`define OFF_STATUS       12'h408

// control word fields
`define CTRL_MODE_MSB    2
`define CTRL_MODE_LSB    0
`define CTRL_DIR_BIT     3
`define CTRL_DMA_REQUEST_ENABLE_BIT   4
`define CTRL_MASK_BIT    5
`define CTRL_THR_MSB     9
`define CTRL_THR_LSB     6
`define CTRL_FLTEN_BIT   10
`define CTRL_ACKEN_BIT   11
`define CTRL_LINES_MSB   15
`define CTRL_LINES_LSB   12
`define CTRL_RESET       32'h0000_0420

// port modes
`define MODE_SPP         3'h0
`define MODE_PS2         3'h1
`define MODE_FIFO        3'h2
`define MODE_ECP         3'h3
`define MODE_TEST        3'h6

// queue geometry and run-length limits
`define FIFO_DEPTH       5'h10
`define FIFO_MAX_THR     4'hF
`define RLE_ADDR_BIT     7

// timing
`define CLK_PERIOD_NS    10
`define IRQ_PULSE_CYC    3'h4
`define DMA_BURST_MAX    6'h20
`define DMA_HOLDOFF_NS   350
`define DMA_HOLDOFF_CYC  \
  ((`DMA_HOLDOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== ecp_fifo_pkg.sv ====
package ecp_fifo_pkg;

  typedef enum logic [1:0] {
    REV_IDLE   = 2'h0,
    REV_COUNT  = 2'h1,
    REV_REPEAT = 2'h3
  } rev_state_t;

  typedef struct packed {
    logic [15:0][8:0] mem;
    logic [3:0]       wrPtr;
    logic [3:0]       rdPtr;
    logic [4:0]       count;
    logic [2:0]       mode;
    logic             dir;
    logic             dma_request_enable;
    logic             mask;
    logic [3:0]       thr;
    logic             faultEnLow;
    logic             ackEn;
    logic [3:0]       lines;
    logic [1:0]       faultSync;
    logic [1:0]       ackSync;
    logic [1:0]       dackSync;
    logic [1:0]       tcSync;
    logic [1:0]       iorSync;
    logic [1:0]       iowSync;
    logic [1:0][7:0]  dwdSync;
    logic             faultPrev;
    logic             ackPrev;
    logic             iorPrev;
    logic             iowPrev;
    logic             tcPrev;
    logic             condPrev;
    logic [2:0]       pulseCnt;
    logic [5:0]       burstCnt;
    logic             holdoff;
    logic [5:0]       idleCnt;
    logic             dmaReq;
    rev_state_t       revState;
    logic [6:0]       rleCount;
    logic [6:0]       rleLeft;
    logic [7:0]       rleByte;
    logic [7:0]       fwdData;
    logic             fwdCmd;
    logic             fwdValid;
    logic [7:0]       dmaReadData;
    logic [31:0]      prdata;
  } state_t;

endpackage

// ==== ecp_fifo_service_logic.sv ====
`timescale 1ns/1ns
`include "ecp_fifo_map.svh"

module ecp_fifo_service_logic (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             portDmaRequest,
  input  wire logic        portDmaAcknowledgeLow,
  input  wire logic        terminalCount,
  input  wire logic        hostReadStrobeLow,
  input  wire logic        hostWriteStrobeLow,
  input  wire logic [7:0]  dmaWriteData,
  output logic      [7:0]  dmaReadData,
  output logic             portInterruptOut,
  output logic             portInterruptOe,
  input  wire logic        peripheralFaultLow,
  input  wire logic        peripheralAcknowledgeLow,
  output logic             dataStrobeLowOut,
  output logic             dataStrobeLowOe,
  output logic             autoFeedLowOut,
  output logic             autoFeedLowOe,
  output logic             peripheralResetLowOut,
  output logic             peripheralResetLowOe,
  output logic             selectInLowOut,
  output logic             selectInLowOe,
  output logic      [7:0]  fwdData,
  output logic             fwdCmd,
  output logic             fwdValid,
  input  wire logic        fwdReady,
  input  wire logic [7:0]  revData,
  input  wire logic        revCmd,
  input  wire logic        revValid,
  output logic             revReady
);
  import ecp_fifo_pkg::*;

  localparam logic [31:0] CtrlReset = `CTRL_RESET;

  state_t      s;
  state_t      n;
  logic        push;
  logic [8:0]  pushData;
  logic        pop;
  logic        doPush;
  logic        doPop;
  logic        full;
  logic        empty;
  logic        fifoOn;
  logic        ecpRev;
  logic        dackActive;
  logic        dmaCycle;
  logic        setup;
  logic        access;
  logic        mapped;
  logic [4:0]  level;
  logic        svcCond;
  logic        gated;
  logic        svcEvent;
  logic        tcEvent;
  logic        faultEvent;
  logic        ackEvent;
  logic        take;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;

  // service level in bytes for a threshold code
  function automatic logic [4:0] serviceLevel(input logic [3:0] code);
    logic [4:0] thrVal;
    thrVal = (code == `FIFO_MAX_THR) ? {1'b0, `FIFO_MAX_THR}
                                     : {1'b0, code} + 5'h01;
    return `FIFO_DEPTH - thrVal;
  endfunction

  assign full       = (s.count == `FIFO_DEPTH);
  assign empty      = (s.count == 5'h00);
  assign fifoOn     = (s.mode == `MODE_FIFO) || (s.mode == `MODE_ECP) ||
                      (s.mode == `MODE_TEST);
  assign ecpRev     = (s.mode == `MODE_ECP) && s.dir;
  assign dackActive = !s.dackSync[1];
  assign dmaCycle   = dackActive &&
                      (s.dir ? (s.iorPrev && !s.iorSync[1])
                             : (!s.iowPrev && s.iowSync[1]));
  assign setup      = psel && !penable;
  assign access     = psel && penable;
  assign mapped     = (paddr == `OFF_ADDR_RLE) || (paddr == `OFF_DATA) ||
                      (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS);
  assign pready     = 1'b1;
  assign pslverr    = access && (!mapped ||
                      (!pwrite && paddr == `OFF_ADDR_RLE));
  assign revReady   = ecpRev && (s.revState != REV_REPEAT) &&
                      (revCmd || !full);
  assign take       = revValid && revReady;

  assign ctrlWord   = {16'h0000, s.lines, s.ackEn, s.faultEnLow, s.thr,
                       s.mask, s.dma_request_enable, s.dir, s.mode};
  assign statusWord = {21'h000000, s.ackSync[1], s.faultSync[1], s.dmaReq,
                       s.condPrev, full, empty, s.count};

  assign level   = serviceLevel(s.thr);
  assign svcCond = fifoOn && !s.dma_request_enable &&
                   (s.dir ? (s.count >= level)
                          : ((`FIFO_DEPTH - s.count) >= level));
  assign gated    = svcCond && !s.mask;
  assign svcEvent = gated && !s.condPrev;

  always_comb begin
    n        = s;
    push     = 1'b0;
    pushData = 9'h000;
    pop      = 1'b0;
    doPush   = 1'b0;
    doPop    = 1'b0;

    n.faultSync = {s.faultSync[0], peripheralFaultLow};
    n.ackSync   = {s.ackSync[0], peripheralAcknowledgeLow};
    n.dackSync  = {s.dackSync[0], portDmaAcknowledgeLow};
    n.tcSync    = {s.tcSync[0], terminalCount};
    n.iorSync   = {s.iorSync[0], hostReadStrobeLow};
    n.iowSync   = {s.iowSync[0], hostWriteStrobeLow};
    n.dwdSync   = {s.dwdSync[0], dmaWriteData};
    n.faultPrev = s.faultSync[1];
    n.ackPrev   = s.ackSync[1];
    n.iorPrev   = s.iorSync[1];
    n.iowPrev   = s.iowSync[1];
    n.tcPrev    = s.tcSync[1] && dackActive;
    n.condPrev  = gated;

    // register reads are prepared during the setup cycle
    if (setup && !pwrite) begin
      case (paddr)
        `OFF_DATA:   n.prdata = empty ? 32'h0
                                      : {24'h0, s.mem[s.rdPtr][7:0]};
        `OFF_CTRL:   n.prdata = ctrlWord;
        `OFF_STATUS: n.prdata = statusWord;
        default:     n.prdata = 32'h0;
      endcase
    end

    if (access && pwrite) begin
      case (paddr)
        `OFF_CTRL: begin
          n.mode       = pwdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
          n.dir        = pwdata[`CTRL_DIR_BIT];
          n.dma_request_enable      = pwdata[`CTRL_DMA_REQUEST_ENABLE_BIT];
          n.mask       = pwdata[`CTRL_MASK_BIT];
          n.thr        = pwdata[`CTRL_THR_MSB:`CTRL_THR_LSB];
          n.faultEnLow = pwdata[`CTRL_FLTEN_BIT];
          n.ackEn      = pwdata[`CTRL_ACKEN_BIT];
          n.lines      = pwdata[`CTRL_LINES_MSB:`CTRL_LINES_LSB];
        end
        `OFF_DATA: begin
          if (fifoOn && (!s.dir || s.mode == `MODE_TEST)) begin
            push     = 1'b1;
            pushData = {1'b0, pwdata[7:0]};
          end
        end
        `OFF_ADDR_RLE: begin
          if (s.mode == `MODE_ECP && !s.dir) begin
            push     = 1'b1;
            pushData = {1'b1, pwdata[7:0]};
          end
        end
        default: ;
      endcase
    end

    if (access && !pwrite && paddr == `OFF_DATA && fifoOn &&
        (s.dir || s.mode == `MODE_TEST)) begin
      pop = 1'b1;
    end

    if (dmaCycle && s.dma_request_enable && fifoOn && s.mode != `MODE_TEST) begin
      if (s.dir) begin
        if (!empty && !pop) begin
          pop           = 1'b1;
          n.dmaReadData = s.mem[s.rdPtr][7:0];
        end
      end else if (!push) begin
        push     = 1'b1;
        pushData = {1'b0, s.dwdSync[1]};
      end
    end

    // forward link drain
    if (s.fwdValid && fwdReady) begin
      n.fwdValid = 1'b0;
    end
    if (!n.fwdValid && !empty && !pop && !s.dir &&
        (s.mode == `MODE_FIFO || s.mode == `MODE_ECP)) begin
      pop        = 1'b1;
      n.fwdValid = 1'b1;
      n.fwdData  = s.mem[s.rdPtr][7:0];
      n.fwdCmd   = s.mem[s.rdPtr][8];
    end

    case (s.revState)
      REV_IDLE, REV_COUNT: begin
        if (take) begin
          if (revCmd) begin
            if (!revData[`RLE_ADDR_BIT]) begin
              n.rleCount = revData[6:0];
              n.revState = REV_COUNT;
            end
          end else begin
            push     = 1'b1;
            pushData = {1'b0, revData};
            if (s.revState == REV_COUNT && s.rleCount != 7'h00) begin
              n.rleByte  = revData;
              n.rleLeft  = s.rleCount;
              n.revState = REV_REPEAT;
            end else begin
              n.revState = REV_IDLE;
            end
          end
        end
      end
      REV_REPEAT: begin
        if (!full) begin
          push      = 1'b1;
          pushData  = {1'b0, s.rleByte};
          n.rleLeft = s.rleLeft - 7'h01;
          if (s.rleLeft == 7'h01) begin
            n.revState = REV_IDLE;
          end
        end
      end
      default: n.revState = REV_IDLE;
    endcase

    doPush = push && !full;
    doPop  = pop && !empty;
    if (doPush) begin
      n.mem[s.wrPtr] = pushData;
      n.wrPtr        = s.wrPtr + 4'h1;
    end
    if (doPop) begin
      n.rdPtr = s.rdPtr + 4'h1;
    end
    n.count = s.count + {4'h0, doPush} - {4'h0, doPop};

    if (!fifoOn || (n.mode != s.mode)) begin
      n.wrPtr    = 4'h0;
      n.rdPtr    = 4'h0;
      n.count    = 5'h00;
      n.revState = REV_IDLE;
      n.fwdValid = 1'b0;
    end

    n.mask = n.mask || tcEvent;

    if (!s.dmaReq) begin
      n.burstCnt = 6'h00;
    end else if (dmaCycle) begin
      if (s.burstCnt == `DMA_BURST_MAX - 6'h01) begin
        n.burstCnt = 6'h00;
        n.holdoff  = 1'b1;
        n.idleCnt  = 6'h00;
      end else begin
        n.burstCnt = s.burstCnt + 6'h01;
      end
    end
    if (s.holdoff) begin
      if (dackActive) begin
        n.idleCnt = 6'h00;
      end else if (s.idleCnt == 6'(`DMA_HOLDOFF_CYC - 1)) begin
        n.holdoff = 1'b0;
      end else begin
        n.idleCnt = s.idleCnt + 6'h01;
      end
    end

    n.dmaReq = fifoOn && s.dma_request_enable && !n.mask && !n.holdoff && !tcEvent &&
               (s.dir ? (!empty && !(s.count == 5'h01 && dackActive))
                      : !full);

    if (svcEvent || tcEvent || faultEvent || ackEvent) begin
      n.pulseCnt = `IRQ_PULSE_CYC;
    end else if (s.pulseCnt != 3'h0) begin
      n.pulseCnt = s.pulseCnt - 3'h1;
    end
  end

  assign tcEvent    = s.tcSync[1] && dackActive && !s.tcPrev &&
                      s.dma_request_enable && !s.mask;
  assign faultEvent = (!s.faultEnLow && s.faultPrev && !s.faultSync[1]) ||
                      (s.faultEnLow && access && pwrite &&
                       paddr == `OFF_CTRL && !pwdata[`CTRL_FLTEN_BIT] &&
                       !s.faultSync[1]);
  assign ackEvent   = s.ackEn && !s.ackPrev && s.ackSync[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s            <= '0;
      s.mode       <= CtrlReset[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      s.mask       <= CtrlReset[`CTRL_MASK_BIT];
      s.faultEnLow <= CtrlReset[`CTRL_FLTEN_BIT];
      s.faultSync  <= 2'h3;
      s.ackSync    <= 2'h3;
      s.dackSync   <= 2'h3;
      s.iorSync    <= 2'h3;
      s.iowSync    <= 2'h3;
      s.faultPrev  <= 1'b1;
      s.ackPrev    <= 1'b1;
      s.iorPrev    <= 1'b1;
      s.iowPrev    <= 1'b1;
      s.revState   <= REV_IDLE;
    end else begin
      s <= n;
    end
  end

  assign prdata           = s.prdata;
  assign portDmaRequest   = s.dmaReq;
  assign dmaReadData      = s.dmaReadData;
  assign portInterruptOut = 1'b0;
  assign portInterruptOe  = (s.pulseCnt != 3'h0);
  assign fwdData          = s.fwdData;
  assign fwdCmd           = s.fwdCmd;
  assign fwdValid         = s.fwdValid;

  assign dataStrobeLowOut      = (s.mode == `MODE_SPP) ? 1'b0 : !s.lines[0];
  assign dataStrobeLowOe       = (s.mode == `MODE_SPP) ? s.lines[0] : 1'b1;
  assign autoFeedLowOut        = (s.mode == `MODE_SPP) ? 1'b0 : !s.lines[1];
  assign autoFeedLowOe         = (s.mode == `MODE_SPP) ? s.lines[1] : 1'b1;
  assign peripheralResetLowOut = (s.mode == `MODE_SPP) ? 1'b0 : !s.lines[2];
  assign peripheralResetLowOe  = (s.mode == `MODE_SPP) ? s.lines[2] : 1'b1;
  assign selectInLowOut        = (s.mode == `MODE_SPP) ? 1'b0 : !s.lines[3];
  assign selectInLowOe         = (s.mode == `MODE_SPP) ? s.lines[3] : 1'b1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rleMaxTaken;
    s.revState == REV_COUNT && s.rleCount == 7'h7F && take && !revCmd;
  endsequence
  sequence irqPulse;
    (portInterruptOe && !portInterruptOut) [*4];
  endsequence

  AST_RLE_ZERO: assert property (
    (s.revState == REV_COUNT && s.rleCount == 7'h00 && take && !revCmd)
      |=> s.revState == REV_IDLE)
    else $error("zero count did not yield a single byte");
  AST_RLE_MAX: assert property (
    rleMaxTaken |=> (s.revState == REV_REPEAT && s.rleLeft == 7'h7F))
    else $error("count 127 did not start 127 repeats");
  AST_OC_MODE: assert property (
    s.mode == `MODE_SPP |-> (!dataStrobeLowOut && !selectInLowOut &&
      dataStrobeLowOe == s.lines[0]))
    else $error("control line driven high in mode 000");
  AST_NO_STALL: assert property (
    access |-> pready)
    else $error("bus stalled");
  AST_MASK_BLOCK: assert property (
    (s.mask && $past(s.mask)) |-> !portDmaRequest)
    else $error("DMA request while masked");
  AST_UNMASK_IRQ: assert property (
    ($fell(s.mask) && svcCond) |-> ##[0:1] portInterruptOe)
    else $error("no interrupt on unmask with condition true");
  AST_PULSE: assert property (
    $rose(portInterruptOe) |-> irqPulse)
    else $error("interrupt pulse too short");
  AST_TC_MASK: assert property (
    tcEvent |=> (s.mask && portInterruptOe) ##1 !portDmaRequest)
    else $error("terminal count did not mask and interrupt");
  AST_HOLDOFF: assert property (
    s.holdoff |-> !portDmaRequest)
    else $error("DMA request during hold-off");
  AST_REV_EMPTY: assert property (
    (s.dir && empty) |=> !portDmaRequest)
    else $error("reverse request with empty FIFO");
  AST_FAULT_IRQ: assert property (
    faultEvent |=> portInterruptOe)
    else $error("fault event lost");
  AST_ACK_IRQ: assert property (
    ackEvent |=> (portInterruptOe && s.pulseCnt == `IRQ_PULSE_CYC))
    else $error("acknowledge event lost");

endmodule

// ==== host_dma_model.sv ====
`timescale 1ns/1ns
module host_dma_model #(
  parameter int         TOTAL = 128,
  parameter logic [7:0] FILL  = 8'h5A
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       portDmaRequest,
  input  wire logic [7:0] dmaReadData,
  output logic            portDmaAcknowledgeLow,
  output logic            terminalCount,
  output logic            hostReadStrobeLow,
  output int              got,
  output int              bad,
  output int              maxRun,
  output int              gapErr
);
  int run;
  int gap;
  initial begin
    portDmaAcknowledgeLow = 1'h1;
    terminalCount = 1'h0;
    hostReadStrobeLow = 1'h1;
    got = 0;
    bad = 0;
    maxRun = 0;
    gapErr = 0;
  end
  always begin
    @(posedge clk);
    if (!rst && portDmaRequest && got < TOTAL) begin
      portDmaAcknowledgeLow <= 1'h0;
      run = 0;
      repeat (3) @(posedge clk);
      while (portDmaRequest && got < TOTAL) begin
        hostReadStrobeLow <= 1'h0;
        terminalCount <= (got == TOTAL - 1);
        repeat (5) @(posedge clk);
        if (dmaReadData !== FILL) bad++;
        hostReadStrobeLow <= 1'h1;
        terminalCount <= 1'h0;
        got++;
        run++;
        if (run > maxRun) maxRun = run;
        repeat (2) @(posedge clk);
      end
      portDmaAcknowledgeLow <= 1'h1;
      gap = 0;
      while (run >= 32 && !portDmaRequest && gap < 60) begin
        @(posedge clk);
        gap++;
      end
      if (run >= 32 && gap < 35) gapErr++;
    end
  end
endmodule

// ==== ecp_fifo_service_logic_test.sv ====
`timescale 1ns/1ns
`include "ecp_fifo_map.svh"
module ecp_fifo_service_logic_test;
  typedef struct packed {
    logic [2:0] md;
    logic [3:0] ln;
    logic [3:0] lo;
    logic [3:0] oe;
  } row_t;
  row_t rows[7] = '{'{3'h0, 4'hF, 4'h0, 4'hF}, '{3'h1, 4'h9, 4'h6, 4'hF},
    '{3'h0, 4'h6, 4'h0, 4'h6}, '{3'h2, 4'h6, 4'h9, 4'hF},
    '{3'h0, 4'h0, 4'h0, 4'h0}, '{3'h3, 4'hF, 4'h0, 4'hF},
    '{3'h0, 4'h0, 4'h0, 4'h0}};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        portDmaRequest, portDmaAcknowledgeLow, terminalCount;
  logic        hostReadStrobeLow, portInterruptOut, portInterruptOe;
  logic [7:0]  dmaReadData, fwdData, revData;
  logic        peripheralFaultLow, peripheralAcknowledgeLow;
  logic        dataStrobeLowOut, dataStrobeLowOe, autoFeedLowOut;
  logic        autoFeedLowOe, peripheralResetLowOut, peripheralResetLowOe;
  logic        selectInLowOut, selectInLowOe;
  logic        fwdCmd, fwdValid, fwdReady, revCmd, revValid, revReady;
  int          errTotal = 0, comparisons = 0, irqs = 0, base = 0, w = 0;
  int          n, k, got, bad, maxRun, gapErr;

  ecp_fifo_service_logic DUT (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .portDmaRequest,
    .portDmaAcknowledgeLow, .terminalCount, .hostReadStrobeLow,
    .hostWriteStrobeLow(1'h1), .dmaWriteData(8'h00), .dmaReadData,
    .portInterruptOut, .portInterruptOe, .peripheralFaultLow,
    .peripheralAcknowledgeLow, .dataStrobeLowOut, .dataStrobeLowOe,
    .autoFeedLowOut, .autoFeedLowOe, .peripheralResetLowOut,
    .peripheralResetLowOe, .selectInLowOut, .selectInLowOe, .fwdData,
    .fwdCmd, .fwdValid, .fwdReady, .revData, .revCmd, .revValid,
    .revReady);
  host_dma_model host (.clk, .rst, .portDmaRequest, .dmaReadData,
    .portDmaAcknowledgeLow, .terminalCount, .hostReadStrobeLow, .got,
    .bad, .maxRun, .gapErr);

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] sn);
    comparisons++;
    if (sn !== ex) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task wrapUp;
    $display("mismatches %0d comparisons %0d", errTotal, comparisons);
    if (errTotal == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task tmo(input int lim);
    if (k >= lim) begin
      errTotal++;
      wrapUp();
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    tmo(20);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    @(posedge clk);
  endtask
  function logic [31:0] cw(input logic [2:0] md, input logic dr, dm, mk,
                           input logic [3:0] th, input logic fe, ae,
                           input logic [3:0] ln);
    return {16'h0000, ln, ae, fe, th, mk, dm, dr, md};
  endfunction
  task setc(input logic [31:0] v);
    apb(1'h1, `OFF_CTRL, v);
  endtask
  task irqChk(input int nx);
    repeat (12) @(posedge clk);
    chk("irqCount", nx, irqs - base);
    base = irqs;
  endtask
  task pop(input logic c, input logic [7:0] d);
    fwdReady <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (fwdValid !== 1'h1 && k < 50);
    tmo(50);
    chk("fwdCmd", c, fwdCmd);
    chk("fwdData", d, fwdData);
    fwdReady <= 1'h0;
    @(posedge clk);
  endtask
  task sendRev(input logic c, input logic [7:0] d);
    revData <= d;
    revCmd <= c;
    revValid <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (revReady !== 1'h1 && k < 2000);
    tmo(2000);
    revValid <= 1'h0;
    revData <= ~d;
    @(posedge clk);
  endtask
  task ackPulse;
    peripheralAcknowledgeLow <= 1'h0;
    repeat (4) @(posedge clk);
    peripheralAcknowledgeLow <= 1'h1;
  endtask

  always @(posedge clk) begin
    if (portInterruptOe === 1'h1) begin
      chk("irqLevel", 0, portInterruptOut);
      w++;
    end else if (w != 0) begin
      chk("irqWidth", 4, w);
      irqs++;
      w = 0;
    end
  end
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, peripheralFaultLow, peripheralAcknowledgeLow} = 3'h7;
    {psel, penable, pwrite, fwdReady, revCmd, revValid} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    revData = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h0, `OFF_CTRL, 0);
    chk("ctrlReset", `CTRL_RESET, r);
    apb(1'h0, `OFF_STATUS, 0);
    chk("statusReset", 32'h20, r & 32'h1FF);
    foreach (rows[i]) begin
      setc(cw(rows[i].md, 0, 0, 1, 0, 1, 0, rows[i].ln));
      chk("lineOut", rows[i].lo, {dataStrobeLowOut, autoFeedLowOut,
          peripheralResetLowOut, selectInLowOut});
      chk("lineOe", rows[i].oe, {dataStrobeLowOe, autoFeedLowOe,
          peripheralResetLowOe, selectInLowOe});
    end
    setc(cw(3'h6, 0, 0, 1, 0, 1, 0, 4'h0));
    apb(1'h1, `OFF_DATA, 32'h77);
    apb(1'h0, `OFF_DATA, 0);
    chk("testQueue", 32'h77, r);
    setc(cw(3'h3, 0, 0, 1, 4'h3, 1, 0, 4'h0));
    apb(1'h1, `OFF_ADDR_RLE, 32'h05);
    n = 1;
    r = 0;
    while (!r[6] && n < 18) begin
      apb(1'h1, `OFF_DATA, 32'(8'(n) + 8'hA0));
      n++;
      apb(1'h0, `OFF_STATUS, 0);
    end
    chk("fullCount", 16, r[4:0]);
    apb(1'h1, `OFF_DATA, 32'hEE);
    setc(cw(3'h3, 0, 0, 0, 4'h3, 1, 0, 4'h0));
    irqChk(0);
    for (int i = 0; i < n; i++) begin
      pop(i == 0, i == 0 ? 8'h05 : 8'(i) + 8'hA0);
      apb(1'h0, `OFF_STATUS, 0);
      irqChk(int'(r[4:0] == 5'h04));
    end
    repeat (5) @(posedge clk);
    chk("fwdIdle", 0, fwdValid);
    setc(cw(3'h0, 0, 0, 1, 0, 1, 1, 0));
    ackPulse();
    irqChk(1);
    setc(cw(3'h0, 0, 0, 1, 0, 1, 0, 0));
    ackPulse();
    irqChk(0);
    peripheralFaultLow <= 1'h0;
    irqChk(0);
    setc(cw(3'h0, 0, 0, 1, 0, 0, 0, 0));
    irqChk(1);
    peripheralFaultLow <= 1'h1;
    repeat (6) @(posedge clk);
    peripheralFaultLow <= 1'h0;
    irqChk(1);
    peripheralFaultLow <= 1'h1;
    setc(cw(3'h0, 0, 0, 1, 0, 1, 0, 0));
    setc(cw(3'h3, 1, 0, 1, 4'hC, 1, 0, 0));
    sendRev(1'h1, 8'h85);
    sendRev(1'h1, 8'h00);
    sendRev(1'h0, 8'h11);
    sendRev(1'h1, 8'h02);
    sendRev(1'h0, 8'h22);
    repeat (10) @(posedge clk);
    apb(1'h0, `OFF_STATUS, 0);
    chk("revCount", 4, r[4:0]);
    irqChk(0);
    setc(cw(3'h3, 1, 0, 0, 4'hC, 1, 0, 0));
    irqChk(1);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, `OFF_DATA, 0);
      chk("revByte", i == 0 ? 8'h11 : 8'h22, r[7:0]);
    end
    apb(1'h0, `OFF_ADDR_RLE, 0);
    chk("addrQueueRead", 1, e);
    apb(1'h0, 12'h40C, 0);
    chk("unmapped", 1, e);
    setc(cw(3'h0, 0, 0, 1, 0, 1, 0, 0));
    setc(cw(3'h3, 1, 1, 1, 0, 1, 0, 0));
    setc(cw(3'h3, 1, 1, 0, 0, 1, 0, 0));
    sendRev(1'h1, 8'h7F);
    sendRev(1'h0, 8'h5A);
    k = 0;
    while (got < 128 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    tmo(20000);
    irqChk(1);
    chk("dmaBytes", 128, got);
    chk("dmaData", 0, bad);
    chk("burstLimit", 1, maxRun <= 32);
    chk("holdoff", 0, gapErr);
    chk("reqAfterTc", 0, portDmaRequest);
    apb(1'h0, `OFF_CTRL, 0);
    chk("maskSet", 1, r[`CTRL_MASK_BIT]);
    apb(1'h0, `OFF_STATUS, 0);
    chk("revEmpty", 0, r[4:0]);
    sendRev(1'h1, 8'h00);
    sendRev(1'h0, 8'h33);
    repeat (10) @(posedge clk);
    chk("reqMasked", 0, portDmaRequest);
    setc(cw(3'h3, 1, 1, 0, 0, 1, 0, 0));
    repeat (6) @(posedge clk);
    chk("reqAgain", 1, portDmaRequest);
    wrapUp();
  end
endmodule
